// file: curb_pkg.sv
/*
 Register bank constants: addresses, fields, resets, command codes.
 Assumes a byte-wide bus with 16-bit extended addresses.
*/
package curb_pkg;
   // Extended-memory addresses
   localparam logic [15:0] ADDR_GENERAL_MODE = 16'h6301;
   localparam logic [15:0] ADDR_TRANSMIT_RATE_FRAMING = 16'h6302;
   localparam logic [15:0] ADDR_RECEIVE_RATE_FRAMING = 16'h6303;
   localparam logic [15:0] ADDR_ANTENNA_DRIVER_CONTROL = 16'h6304;
   localparam logic [15:0] ADDR_ANTENNA_DRIVER_AUTO = 16'h6305;
   localparam logic [15:0] ADDR_TRANSMITTER_SOURCE_SELECT = 16'h6306;
   localparam logic [15:0] ADDR_RECEIVER_SELECT = 16'h6307;
   localparam logic [15:0] ADDR_BIT_DECODER_THRESHOLD = 16'h6308;
   localparam logic [15:0] ADDR_DEMODULATOR_SETTINGS = 16'h6309;
   localparam logic [15:0] ADDR_SYNC_AND_MIN_LENGTH = 16'h630A;
   localparam logic [15:0] ADDR_MAX_FRAME_LENGTH = 16'h630B;
   localparam logic [15:0] ADDR_TYPE_A_TARGET_SETTINGS = 16'h630C;
   localparam logic [15:0] ADDR_RECEIVER_MANUAL_TUNING = 16'h630D;
   localparam logic [15:0] ADDR_TYPE_B_SETTINGS = 16'h630E;
   localparam logic [15:0] ADDR_CRC_RESULT_HIGH = 16'h6311;
   localparam logic [15:0] ADDR_CRC_RESULT_LOW = 16'h6312;
   localparam logic [15:0] ADDR_N_DRIVER_IDLE_CONDUCTANCE = 16'h6313;
   localparam logic [15:0] ADDR_MODULATION_WIDTH = 16'h6314;
   localparam logic [15:0] ADDR_TRANSMIT_BIT_PHASE = 16'h6315;
   localparam logic [15:0] ADDR_RECEIVER_GAIN_CONFIG = 16'h6316;
   localparam logic [15:0] ADDR_SECURE_CLOCK_ENABLE = 16'h6330;
   localparam logic [15:0] ADDR_COMMAND_CONTROL = 16'h6331;
   localparam logic [15:0] ADDR_COMMON_IRQ_ENABLE = 16'h6332;
   localparam logic [15:0] ADDR_MISC_IRQ_ENABLE = 16'h6333;
   localparam logic [15:0] ADDR_COMMON_IRQ_FLAGS = 16'h6334;
   localparam logic [15:0] ADDR_MISC_IRQ_FLAGS = 16'h6335;
   localparam logic [15:0] ADDR_ERROR_FLAGS = 16'h6336;
   localparam logic [15:0] ADDR_STATUS_ONE = 16'h6337;
   localparam logic [15:0] ADDR_STATUS_TWO = 16'h6338;
   localparam logic [15:0] ADDR_BUFFER_DATA_PORT = 16'h6339;
   localparam logic [15:0] ADDR_BUFFER_LEVEL = 16'h633A;
   localparam logic [15:0] ADDR_BUFFER_WATERMARK = 16'h633B;
   localparam logic [15:0] ADDR_MISC_CONTROL = 16'h633C;
   localparam logic [15:0] ADDR_BIT_FRAMING = 16'h633D;
   localparam logic [15:0] ADDR_COLLISION_POSITION = 16'h633E;
   // Special-function aliases of the high-traffic registers
   localparam logic [7:0] SFR_COMMAND_CONTROL = 8'hD1;
   localparam logic [7:0] SFR_COMMON_IRQ_ENABLE = 8'hD2;
   localparam logic [7:0] SFR_MISC_IRQ_ENABLE = 8'hD3;
   localparam logic [7:0] SFR_COMMON_IRQ_FLAGS = 8'hD4;
   localparam logic [7:0] SFR_MISC_IRQ_FLAGS = 8'hD5;
   localparam logic [7:0] SFR_ERROR_FLAGS = 8'hD6;
   localparam logic [7:0] SFR_STATUS_ONE = 8'hDF;
   localparam logic [7:0] SFR_STATUS_TWO = 8'hE9;
   localparam logic [7:0] SFR_BUFFER_DATA_PORT = 8'hEA;
   localparam logic [7:0] SFR_BUFFER_LEVEL = 8'hEB;
   localparam logic [7:0] SFR_BUFFER_WATERMARK = 8'hEC;
   localparam logic [7:0] SFR_MISC_CONTROL = 8'hED;
   localparam logic [7:0] SFR_BIT_FRAMING = 8'hEE;
   localparam logic [7:0] SFR_COLLISION_POSITION = 8'hEF;
   // Field positions
   localparam int BIT_SECOND_INVERT_ON = 7;
   localparam int BIT_SECOND_INVERT_OFF = 5;
   localparam int BIT_SECOND_RF_ENABLE = 1;
   localparam int BIT_FIRST_RF_ENABLE = 0;
   localparam int BIT_SECOND_AUTO_ENABLE = 3;
   localparam int BIT_FIRST_AUTO_ENABLE = 2;
   localparam int BIT_MSB_FIRST = 7;
   localparam int BIT_MISC_SET_CONTROL = 7;
   localparam int BIT_TEMPERATURE_ERROR = 6;
   localparam int BIT_LEVEL_FLUSH = 7;
   localparam int BIT_STATUS_LOW_ALERT = 0;
   localparam int BIT_STATUS_HIGH_ALERT = 1;
   localparam int BIT_SECURE_CLOCK_ON = 0;
   localparam int BIT_STOP_EXECUTION = 4;
   // Command field and code
   localparam logic [3:0] CMD_IDLE = 4'h0;
   localparam logic [7:0] ERROR_KEEP_MASK = 8'h40;
   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] RESET_WATERMARK = 8'h08;
   localparam logic [7:0] RESET_COLLISION = 8'h80;
endpackage

// file: curb_register_bank.sv
/*
 Contactless unit register bank: command,
 interrupt enables and flags, errors, status,
 64-byte buffer, drivers, framing, CRC bytes.
 Assumes one clock, synchronous active-high reset,
 and core events, errors and CRC on that clock.
*/
// How it works
// - One data port writes and reads a 64-byte FIFO.
// - Level register shows the bytes held.
// - Watermark sets near-empty and near-full warnings.
// - Command write starts a command; a stop bit halts it.
// - Command answers at its alias and extended address.
// - Enables gate request flags onto the interrupt line.
// - Misc flags latch past their cause.
// - Misc flags read zero after reset, until set by events or writes.
// - Error register holds the last command's errors.
// - Start clears errors but temperature; writes never set.
// - Collision register keeps the first collision position.
// - On-inversion with second RF enable inverts second driver.
// - Off-inversion without it inverts too, auto mode only.
// - First RF enable drives the modulated carrier out.
// - CRC reads as separate read-only high and low bytes.
// - MSB-first reverses bits per CRC byte, not byte order.
// - A register tunes transmit bit phase at the lowest rate.
// - One register holds sync length and minimum frame length.
// - Maximum frame length has its own register.
// - An enable routes the secure-element clock to the port pin.
`timescale 1ns/1ps
`default_nettype none
module curb_register_bank
   import curb_pkg::*;
#(
   parameter int DEPTH = 64,
   parameter int LEVEL_W = 7
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Controller register port
   input wire logic reg_sel_sfr,
   input wire logic [15:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // Unit core events
   input wire logic [7:0] core_common_events,
   input wire logic [4:0] core_misc_events,
   input wire logic core_command_done,
   input wire logic [7:0] core_error_events,
   input wire logic [15:0] core_crc,
   input wire logic core_collision,
   input wire logic [7:0] core_collision_pos,
   input wire logic [7:0] core_status_one,
   input wire logic [7:0] core_status_two,
   input wire logic core_buf_push,
   input wire logic [7:0] core_buf_wdata,
   input wire logic core_buf_pop,
   // Unit core controls
   output logic [3:0] command_code,
   output logic command_start,
   output logic command_stop,
   output logic [7:0] buf_head,
   output logic buf_empty,
   output logic buf_full,
   output logic [7:0] general_mode,
   output logic [7:0] transmit_rate_framing,
   output logic [7:0] receive_rate_framing,
   output logic [7:0] antenna_driver_auto,
   output logic [7:0] transmit_bit_phase,
   output logic [7:0] sync_and_min_length,
   output logic [7:0] max_frame_length,
   output logic [7:0] misc_control,
   output logic [7:0] bit_framing,
   // Antenna and pins
   input wire logic carrier_modulated,
   output logic first_antenna_output,
   output logic second_antenna_output,
   output logic secure_element_clock_sel,
   output logic irq
);
   import curb_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [5:0] wr_ptr;
      logic [5:0] rd_ptr;
      logic [LEVEL_W-1:0] level;
      logic [14:0][7:0] cfg;
      logic [7:0] phase;
      logic [7:0] command;
      logic [7:0] common_en;
      logic [7:0] misc_en;
      logic [7:0] common_flags;
      logic [4:0] misc_flags;
      logic [7:0] error_flags;
      logic [7:0] watermark;
      logic [7:0] collision;
      logic coll_seen;
      logic [7:0] rdata;
      logic start;
      logic stop;
   } curb_state_s;

   curb_state_s st, next_st;

   // Reverse bits within one byte
   function automatic logic [7:0] curb_rev(input logic [7:0] b);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7 - i];
      end
      return r;
   endfunction

   // Alias to extended address; both reach one storage
   function automatic logic [15:0] curb_map(input logic sfr,
                                             input logic [15:0] a);
      logic [15:0] m;
      m = a;
      if (sfr) begin
         case (a[7:0])
            SFR_COMMAND_CONTROL: m = ADDR_COMMAND_CONTROL;
            SFR_COMMON_IRQ_ENABLE: m = ADDR_COMMON_IRQ_ENABLE;
            SFR_MISC_IRQ_ENABLE: m = ADDR_MISC_IRQ_ENABLE;
            SFR_COMMON_IRQ_FLAGS: m = ADDR_COMMON_IRQ_FLAGS;
            SFR_MISC_IRQ_FLAGS: m = ADDR_MISC_IRQ_FLAGS;
            SFR_ERROR_FLAGS: m = ADDR_ERROR_FLAGS;
            SFR_STATUS_ONE: m = ADDR_STATUS_ONE;
            SFR_STATUS_TWO: m = ADDR_STATUS_TWO;
            SFR_BUFFER_DATA_PORT: m = ADDR_BUFFER_DATA_PORT;
            SFR_BUFFER_LEVEL: m = ADDR_BUFFER_LEVEL;
            SFR_BUFFER_WATERMARK: m = ADDR_BUFFER_WATERMARK;
            SFR_MISC_CONTROL: m = ADDR_MISC_CONTROL;
            SFR_BIT_FRAMING: m = ADDR_BIT_FRAMING;
            SFR_COLLISION_POSITION: m = ADDR_COLLISION_POSITION;
            default: m = 16'h0000;
         endcase
      end
      return m;
   endfunction

   logic [15:0] addr;
   logic known;
   logic is_cfg;
   logic [3:0] cfg_idx;
   logic [7:0] rd_val;
   logic cpu_push, cpu_pop, do_push, do_pop, flush;
   logic low_alert, high_alert;
   logic [7:0] crc_hi, crc_lo;
   logic [7:0] status_one_val;

   // Decode; 6301..630E sit in one array
   always_comb begin
      addr = curb_map(reg_sel_sfr, reg_addr);
      is_cfg = 1'b0;
      cfg_idx = 4'h0;
      if (addr >= ADDR_GENERAL_MODE && addr <= ADDR_TYPE_B_SETTINGS) begin
         is_cfg = 1'b1;
         cfg_idx = 4'(addr - ADDR_GENERAL_MODE);
      end
      known = is_cfg || addr == ADDR_CRC_RESULT_HIGH ||
              addr == ADDR_CRC_RESULT_LOW ||
              (addr >= ADDR_N_DRIVER_IDLE_CONDUCTANCE &&
               addr <= ADDR_RECEIVER_GAIN_CONFIG) ||
              (addr >= ADDR_SECURE_CLOCK_ENABLE &&
               addr <= ADDR_COLLISION_POSITION);
   end

   // Buffer thresholds and CRC view
   always_comb begin
      buf_empty = st.level == '0;
      buf_full = st.level == LEVEL_W'(DEPTH);
      low_alert = {1'b0, st.level} <= {1'b0, st.watermark[LEVEL_W-1:0]};
      high_alert = (LEVEL_W'(DEPTH) - st.level) <=
                   st.watermark[LEVEL_W-1:0];
      // Bits flip per byte; bytes keep their places
      crc_hi = st.cfg[0][BIT_MSB_FIRST] ? curb_rev(core_crc[15:8])
                                         : core_crc[15:8];
      crc_lo = st.cfg[0][BIT_MSB_FIRST] ? curb_rev(core_crc[7:0])
                                         : core_crc[7:0];
      status_one_val = core_status_one;
      status_one_val[BIT_STATUS_LOW_ALERT] = low_alert;
      status_one_val[BIT_STATUS_HIGH_ALERT] = high_alert;
   end

   // Core and controller share one pointer pair
   always_comb begin
      cpu_push = reg_write && addr == ADDR_BUFFER_DATA_PORT;
      cpu_pop = reg_read && addr == ADDR_BUFFER_DATA_PORT;
      flush = reg_write && addr == ADDR_BUFFER_LEVEL &&
              reg_wdata[BIT_LEVEL_FLUSH];
      do_push = (cpu_push || core_buf_push) && !buf_full;
      do_pop = (cpu_pop || core_buf_pop) && !buf_empty;
   end

   // Read mux
   always_comb begin
      rd_val = 8'h00;
      if (is_cfg) begin
         rd_val = st.cfg[cfg_idx];
      end else begin
         case (addr)
            ADDR_CRC_RESULT_HIGH: rd_val = crc_hi;
            ADDR_CRC_RESULT_LOW: rd_val = crc_lo;
            ADDR_N_DRIVER_IDLE_CONDUCTANCE: rd_val = st.cfg[14];
            ADDR_MODULATION_WIDTH: rd_val = st.cfg[14]; // spare
            ADDR_TRANSMIT_BIT_PHASE: rd_val = st.phase;
            ADDR_SECURE_CLOCK_ENABLE: rd_val = st.cfg[14];
            ADDR_COMMAND_CONTROL: rd_val = st.command;
            ADDR_COMMON_IRQ_ENABLE: rd_val = st.common_en;
            ADDR_MISC_IRQ_ENABLE: rd_val = st.misc_en;
            ADDR_COMMON_IRQ_FLAGS: rd_val = st.common_flags;
            ADDR_MISC_IRQ_FLAGS: rd_val = {3'b000, st.misc_flags};
            ADDR_ERROR_FLAGS: rd_val = st.error_flags;
            ADDR_STATUS_ONE: rd_val = status_one_val;
            ADDR_STATUS_TWO: rd_val = core_status_two;
            ADDR_BUFFER_DATA_PORT: rd_val = st.mem[st.rd_ptr];
            ADDR_BUFFER_LEVEL: rd_val = 8'(st.level);
            ADDR_BUFFER_WATERMARK: rd_val = st.watermark;
            ADDR_MISC_CONTROL: rd_val = st.cfg[14];
            ADDR_BIT_FRAMING: rd_val = st.cfg[14];
            ADDR_COLLISION_POSITION: rd_val = st.collision;
            default: rd_val = 8'h00;
         endcase
      end
   end

   // Next state
   always_comb begin
      next_st = st;
      next_st.start = 1'b0;
      next_st.stop = 1'b0;
      if (reg_read) begin
         next_st.rdata = rd_val;
      end
      // Buffer storage and fill level
      if (flush) begin
         next_st.wr_ptr = 6'h00;
         next_st.rd_ptr = 6'h00;
         next_st.level = '0;
      end else begin
         if (do_push) begin
            next_st.mem[st.wr_ptr] = cpu_push ? reg_wdata : core_buf_wdata;
            next_st.wr_ptr = st.wr_ptr + 6'h01;
         end
         if (do_pop) begin
            next_st.rd_ptr = st.rd_ptr + 6'h01;
         end
         next_st.level = st.level + LEVEL_W'(do_push) -
                         LEVEL_W'(do_pop);
      end
      // Register writes
      if (reg_write) begin
         if (is_cfg) begin
            next_st.cfg[cfg_idx] = reg_wdata;
         end
         case (addr)
            ADDR_COMMAND_CONTROL: begin
               next_st.command = reg_wdata;
               next_st.start = reg_wdata[3:0] != CMD_IDLE &&
                               !reg_wdata[BIT_STOP_EXECUTION];
               next_st.stop = reg_wdata[BIT_STOP_EXECUTION];
            end
            ADDR_COMMON_IRQ_ENABLE: next_st.common_en = reg_wdata;
            ADDR_MISC_IRQ_ENABLE: next_st.misc_en = reg_wdata;
            // Firmware clears by writing zeros
            ADDR_COMMON_IRQ_FLAGS: next_st.common_flags = reg_wdata;
            ADDR_MISC_IRQ_FLAGS: begin
               if (reg_wdata[BIT_MISC_SET_CONTROL]) begin
                  next_st.misc_flags = st.misc_flags | reg_wdata[4:0];
               end else begin
                  next_st.misc_flags = st.misc_flags & ~reg_wdata[4:0];
               end
            end
            ADDR_BUFFER_WATERMARK: next_st.watermark = reg_wdata;
            ADDR_TRANSMIT_BIT_PHASE: next_st.phase = reg_wdata;
            ADDR_SECURE_CLOCK_ENABLE: next_st.cfg[14] = reg_wdata;
            default: ;
         endcase
      end
      // A start clears errors but temperature
      if (next_st.start) begin
         next_st.error_flags = st.error_flags & ERROR_KEEP_MASK;
         next_st.coll_seen = 1'b0;
      end
      next_st.error_flags = next_st.error_flags | core_error_events;
      // Hardware events win over a clear in the same cycle
      next_st.common_flags = next_st.common_flags | core_common_events;
      next_st.misc_flags = next_st.misc_flags | core_misc_events;
      if (core_command_done) begin
         next_st.command[3:0] = CMD_IDLE;
      end
      // First collision after reset or a start only
      if (core_collision && !next_st.coll_seen) begin
         next_st.collision = core_collision_pos;
         next_st.coll_seen = 1'b1;
      end
   end

   // State register; misc flags reset to a defined zero
   always_ff @(posedge clk) begin
      if (reset) begin
         st.mem <= '0;
         st.wr_ptr <= 6'h00;
         st.rd_ptr <= 6'h00;
         st.level <= '0;
         for (int i = 0; i < 15; i++) begin
            st.cfg[i] <= RESET_BYTE;
         end
         st.phase <= RESET_BYTE;
         st.command <= RESET_BYTE;
         st.common_en <= RESET_BYTE;
         st.misc_en <= RESET_BYTE;
         st.common_flags <= RESET_BYTE;
         st.misc_flags <= 5'h00;
         st.error_flags <= RESET_BYTE;
         st.watermark <= RESET_WATERMARK;
         st.collision <= RESET_COLLISION;
         st.coll_seen <= 1'b0;
         st.rdata <= RESET_BYTE;
         st.start <= 1'b0;
         st.stop <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   logic second_level;
   always_comb begin
      reg_rdata = st.rdata;
      reg_hit = (reg_read || reg_write) && known;
      command_code = st.command[3:0];
      command_start = st.start;
      command_stop = st.stop;
      buf_head = st.mem[st.rd_ptr];
      general_mode = st.cfg[0];
      transmit_rate_framing = st.cfg[1];
      receive_rate_framing = st.cfg[2];
      antenna_driver_auto = st.cfg[4];
      sync_and_min_length = st.cfg[9];
      max_frame_length = st.cfg[10];
      transmit_bit_phase = st.phase;
      misc_control = 8'h00;
      bit_framing = 8'h00;
      secure_element_clock_sel = st.cfg[14][BIT_SECURE_CLOCK_ON];
      irq = |(st.common_flags & st.common_en) |
            |(st.misc_flags & st.misc_en[4:0]);
      first_antenna_output = st.cfg[3][BIT_FIRST_RF_ENABLE] &&
                             carrier_modulated;
      second_level = st.cfg[3][BIT_SECOND_RF_ENABLE] && carrier_modulated;
      second_antenna_output = second_level;
      if (st.cfg[3][BIT_SECOND_RF_ENABLE] &&
          st.cfg[3][BIT_SECOND_INVERT_ON]) begin
         second_antenna_output = !second_level;
      end
      // Off-state inversion needs both auto enables set
      if (!st.cfg[3][BIT_SECOND_RF_ENABLE] &&
          st.cfg[3][BIT_SECOND_INVERT_OFF] &&
          st.cfg[4][BIT_SECOND_AUTO_ENABLE] &&
          st.cfg[4][BIT_FIRST_AUTO_ENABLE]) begin
         second_antenna_output = !second_level;
      end
   end
endmodule
`default_nettype wire

// file: curb_register_bank_checker.sv
/*
 Port-level checker for the register bank.
 Assumes one clock and synchronous reset; bound at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module curb_checker
   import curb_pkg::*;
(
   // Clock, reset and register port
   input wire logic clk,
   input wire logic reset,
   input wire logic reg_sel_sfr,
   input wire logic [15:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   // Core side and bank outputs
   input wire logic core_command_done,
   input wire logic [15:0] core_crc,
   input wire logic [3:0] command_code,
   input wire logic command_start,
   input wire logic command_stop,
   input wire logic buf_empty,
   input wire logic buf_full,
   input wire logic [7:0] general_mode,
   input wire logic secure_element_clock_sel,
   input wire logic irq
);
   logic cmd_wr;
   // Command writes by alias or extended address
   assign cmd_wr = reg_write && (reg_sel_sfr ?
      reg_addr[7:0] == SFR_COMMAND_CONTROL : reg_addr == ADDR_COMMAND_CONTROL);
   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         rev8[i] = v[7 - i];
      end
   endfunction
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   chk_cmd_start: assert property (
      cmd_wr && reg_wdata[3:0] != CMD_IDLE && !reg_wdata[BIT_STOP_EXECUTION]
      |=> command_start ##1 !command_start) else $error("start pulse");
   chk_cmd_stop: assert property (
      cmd_wr && reg_wdata[BIT_STOP_EXECUTION] |=> command_stop && !command_start)
      else $error("stop pulse");
   chk_idle_return: assert property (
      core_command_done |=> command_code == CMD_IDLE) else $error("not idle");
   chk_alias_hit: assert property (
      (reg_read || reg_write) && reg_sel_sfr
      && reg_addr[7:0] == SFR_COMMAND_CONTROL |-> reg_hit) else $error("alias");
   chk_flush_empty: assert property (
      reg_write && !reg_sel_sfr && reg_addr == ADDR_BUFFER_LEVEL
      && reg_wdata[BIT_LEVEL_FLUSH] |=> buf_empty && !buf_full)
      else $error("flush");
   chk_rdata_hold: assert property (
      !reg_read |=> $stable(reg_rdata)) else $error("read data moved");
   chk_crc_high: assert property (
      reg_read && !reg_sel_sfr && reg_addr == ADDR_CRC_RESULT_HIGH
      && !general_mode[BIT_MSB_FIRST] |=> reg_rdata == $past(core_crc[15:8]))
      else $error("crc high");
   chk_crc_rev: assert property (
      reg_read && !reg_sel_sfr && reg_addr == ADDR_CRC_RESULT_LOW
      && general_mode[BIT_MSB_FIRST]
      |=> reg_rdata == rev8($past(core_crc[7:0])))
      else $error("crc order");
   chk_sck_enable: assert property (
      reg_write && !reg_sel_sfr && reg_addr == ADDR_SECURE_CLOCK_ENABLE
      |=> secure_element_clock_sel == $past(reg_wdata[BIT_SECURE_CLOCK_ON]))
      else $error("secure clock");
   chk_irq_quiet: assert property (
      $fell(reset) |-> !irq) else $error("irq after reset");
   // Main scenarios reached
   cover property (command_start);
   cover property (buf_full);
   cover property (irq);
endmodule
bind curb_register_bank curb_checker i_chk (.clk, .reset, .reg_sel_sfr,
   .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata, .reg_hit,
   .core_command_done, .core_crc, .command_code, .command_start,
   .command_stop, .buf_empty, .buf_full, .general_mode,
   .secure_element_clock_sel, .irq);
`default_nettype wire

// file: tb_curb_register_bank.sv
/*
 Self-checking bench for the contactless unit register bank.
 Assumes the bank's own register port; inputs change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_curb_register_bank;
   import curb_pkg::*;
   logic clk = 1'b0, reset = 1'b1, reg_sel_sfr = 1'b0, reg_write = 1'b0;
   logic reg_read = 1'b0, core_command_done = 1'b0, core_collision = 1'b0;
   logic core_buf_push = 1'b0, core_buf_pop = 1'b0, carrier_modulated = 1'b0;
   logic [15:0] reg_addr = 16'h0000, core_crc = 16'h0000;
   logic [7:0] reg_wdata = 8'h00, core_common_events = 8'h00, d;
   logic [7:0] core_error_events = 8'h00, core_collision_pos = 8'h00;
   logic [7:0] core_status_one = 8'h00, core_status_two = 8'h00;
   logic [7:0] core_buf_wdata = 8'h00, reg_rdata, sync_and_min_length;
   logic [7:0] max_frame_length;
   logic [4:0] core_misc_events = 5'h00;
   logic [3:0] command_code;
   logic reg_hit, command_start, command_stop, buf_empty, buf_full, hit;
   logic first_antenna_output, second_antenna_output, irq;
   logic secure_element_clock_sel;
   logic [15:0] cfg [4];
   int n_fail = 0, comparisons = 0;
   curb_register_bank i_dut (.clk, .reset, .reg_sel_sfr, .reg_addr,
      .reg_write, .reg_read, .reg_wdata, .reg_rdata, .reg_hit,
      .core_common_events, .core_misc_events, .core_command_done,
      .core_error_events, .core_crc, .core_collision, .core_collision_pos,
      .core_status_one, .core_status_two, .core_buf_push, .core_buf_wdata,
      .core_buf_pop, .command_code, .command_start, .command_stop,
      .buf_head(), .buf_empty, .buf_full, .general_mode(),
      .transmit_rate_framing(), .receive_rate_framing(),
      .antenna_driver_auto(), .transmit_bit_phase(), .sync_and_min_length,
      .max_frame_length, .misc_control(), .bit_framing(), .carrier_modulated,
      .first_antenna_output, .second_antenna_output,
      .secure_element_clock_sel, .irq);
   // 10 MHz core clock
   always #50 clk = ~clk;
   task automatic final_report;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         $display("wrong value %s exp %h seen %h", n, e, s);
         n_fail++;
      end
   endtask
   task automatic cb(input string n, input logic s, input logic e);
      chk(n, {7'h00, s}, {7'h00, e});
   endtask
   // Strobes stand until the next call or an idle step
   task automatic wr(input logic s, input logic [15:0] a, input logic [7:0] v);
      reg_sel_sfr = s;
      reg_addr = a;
      reg_wdata = v;
      reg_read = 1'b0;
      reg_write = 1'b1;
      @(negedge clk);
   endtask
   task automatic rd(input logic s, input logic [15:0] a);
      reg_sel_sfr = s;
      reg_addr = a;
      reg_write = 1'b0;
      reg_read = 1'b1;
      #1 hit = reg_hit;
      @(negedge clk);
      d = reg_rdata;
   endtask
   task automatic rc(input logic s, input logic [15:0] a, input logic [7:0] e);
      rd(s, a);
      chk("reg", d, e);
   endtask
   task automatic step;
      reg_write = 1'b0;
      reg_read = 1'b0;
      @(negedge clk);
   endtask
   // A hang still reaches the verdict
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report;
   end
   // Main sequence
   initial begin
      cfg = '{ADDR_SYNC_AND_MIN_LENGTH, ADDR_MAX_FRAME_LENGTH,
         ADDR_TRANSMIT_BIT_PHASE, ADDR_SECURE_CLOCK_ENABLE};
      repeat (5) step;
      reset = 1'b0;
      rc(1, SFR_BUFFER_WATERMARK, RESET_WATERMARK);
      rc(0, ADDR_COLLISION_POSITION, RESET_COLLISION);
      rd(0, ADDR_STATUS_ONE);
      chk("alert", d & 8'h03, 8'h01);
      rd(0, 16'h6320);
      cb("hit", hit, 1'b0);
      // Errors survive writes; a start clears all but temperature
      core_error_events = 8'h41;
      step;
      core_error_events = 8'h00;
      wr(0, ADDR_ERROR_FLAGS, 8'h00);
      rc(1, SFR_ERROR_FLAGS, 8'h41);
      wr(1, SFR_COMMAND_CONTROL, 8'h03);
      cb("start", command_start, 1'b1);
      rc(0, ADDR_COMMAND_CONTROL, 8'h03);
      rc(1, SFR_ERROR_FLAGS, 8'h40);
      // First collision after a start is kept
      core_collision_pos = 8'h05;
      core_collision = 1'b1;
      step;
      core_collision_pos = 8'h09;
      step;
      core_collision = 1'b0;
      rc(1, SFR_COLLISION_POSITION, 8'h05);
      wr(0, ADDR_COMMAND_CONTROL, 8'h13);
      chk("stop", {6'h00, command_stop, command_start}, 8'h02);
      core_command_done = 1'b1;
      step;
      core_command_done = 1'b0;
      chk("idle", {4'h0, command_code}, {4'h0, CMD_IDLE});
      // Latched flags; control bit sets or clears
      wr(1, SFR_MISC_IRQ_FLAGS, 8'h00);
      core_misc_events = 5'h04;
      step;
      core_misc_events = 5'h00;
      step;
      rc(1, SFR_MISC_IRQ_FLAGS, 8'h04);
      wr(0, ADDR_MISC_IRQ_FLAGS, 8'h81);
      rc(0, ADDR_MISC_IRQ_FLAGS, 8'h05);
      wr(0, ADDR_MISC_IRQ_FLAGS, 8'h04);
      rc(0, ADDR_MISC_IRQ_FLAGS, 8'h01);
      wr(1, SFR_MISC_IRQ_ENABLE, 8'h01);
      cb("irq", irq, 1'b1);
      wr(1, SFR_MISC_IRQ_ENABLE, 8'h00);
      cb("irq", irq, 1'b0);
      core_common_events = 8'h01;
      step;
      core_common_events = 8'h00;
      cb("irq", irq, 1'b0);
      wr(1, SFR_COMMON_IRQ_ENABLE, 8'h01);
      rc(1, SFR_COMMON_IRQ_FLAGS, 8'h01);
      cb("irq", irq, 1'b1);
      wr(1, SFR_COMMON_IRQ_FLAGS, 8'h00);
      cb("irq", irq, 1'b0);
      // Overfill, read, flush, core side
      for (int i = 0; i < 65; i++) wr(1, SFR_BUFFER_DATA_PORT, 8'(i));
      rc(1, SFR_BUFFER_LEVEL, 8'h40);
      cb("full", buf_full, 1'b1);
      rd(0, ADDR_STATUS_ONE);
      chk("alert", d & 8'h03, 8'h02);
      rc(1, SFR_BUFFER_DATA_PORT, 8'h00);
      rc(1, SFR_BUFFER_LEVEL, 8'h3F);
      wr(0, ADDR_BUFFER_LEVEL, 8'h80);
      rc(0, ADDR_BUFFER_LEVEL, 8'h00);
      wr(1, SFR_BUFFER_DATA_PORT, 8'h11);
      wr(1, SFR_BUFFER_DATA_PORT, 8'h22);
      core_buf_pop = 1'b1;
      step;
      core_buf_pop = 1'b0;
      core_buf_push = 1'b1;
      core_buf_wdata = 8'h5A;
      step;
      core_buf_push = 1'b0;
      rc(1, SFR_BUFFER_DATA_PORT, 8'h22);
      rc(1, SFR_BUFFER_DATA_PORT, 8'h5A);
      rc(1, SFR_BUFFER_LEVEL, 8'h00);
      // CRC bytes are read-only; mode bit flips bit order
      core_crc = 16'hC012;
      wr(0, ADDR_CRC_RESULT_HIGH, 8'hFF);
      rc(0, ADDR_CRC_RESULT_HIGH, 8'hC0);
      rc(0, ADDR_CRC_RESULT_LOW, 8'h12);
      wr(0, ADDR_GENERAL_MODE, 8'h80);
      rc(0, ADDR_CRC_RESULT_HIGH, 8'h03);
      rc(0, ADDR_CRC_RESULT_LOW, 8'h48);
      // Framing, phase and secure clock settings
      foreach (cfg[i]) wr(0, cfg[i], 8'(2 * i + 1));
      foreach (cfg[i]) rc(0, cfg[i], 8'(2 * i + 1));
      chk("min_len", sync_and_min_length, 8'h01);
      chk("max_len", max_frame_length, 8'h03);
      cb("sck", secure_element_clock_sel, 1'b1);
      // Driver inversion, auto enables on
      wr(0, ADDR_ANTENNA_DRIVER_AUTO, 8'h0C);
      carrier_modulated = 1'b1;
      wr(0, ADDR_ANTENNA_DRIVER_CONTROL, 8'h03);
      cb("first", first_antenna_output, 1'b1);
      wr(0, ADDR_ANTENNA_DRIVER_CONTROL, 8'h83);
      cb("inv_on", second_antenna_output, 1'b0);
      wr(0, ADDR_ANTENNA_DRIVER_CONTROL, 8'h21);
      cb("inv_off", second_antenna_output, 1'b1);
      carrier_modulated = 1'b0;
      #1 cb("first", first_antenna_output, 1'b0);
      step;
      final_report;
   end
endmodule
`default_nettype wire
